// ==== hw/uad_regs.vh ====
// Register map, field positions, reset values and timing counts of the accessory detector
`ifndef UAD_REGS_VH
`define UAD_REGS_VH
`define UAD_ADDR_CONTROL 8'h02
`define UAD_ADDR_IRQ_FIRST 8'h03
`define UAD_ADDR_IRQ_SECOND 8'h04
`define UAD_ADDR_MASK_FIRST 8'h05
`define UAD_ADDR_MASK_SECOND 8'h06
`define UAD_ADDR_ID_CODE 8'h07
`define UAD_ADDR_TIMING_FIRST 8'h08
`define UAD_ADDR_TIMING_SECOND 8'h09
`define UAD_ADDR_TYPE_FIRST 8'h0A
`define UAD_ADDR_TYPE_SECOND 8'h0B
`define UAD_ADDR_BUTTON_FIRST 8'h0C
`define UAD_ADDR_BUTTON_SECOND 8'h0D
`define UAD_ADDR_CAR_KIT 8'h0E
`define UAD_CTRL_RESET 8'h1F
`define UAD_CTRL_BLOCK_BIT 0
`define UAD_TIMING_RESET 8'h00
`define UAD_MASK_RESET 8'h00
`define UAD_IRQ_ATTACH 0
`define UAD_IRQ_DETACH 1
`define UAD_IRQ2_RESERVED 0
`define UAD_IRQ2_CODE_CHANGE 2
`define UAD_WAIT_UNIT_MS 1
`define UAD_CLK_HZ 20000000
`define UAD_CYC_PER_MS (`UAD_CLK_HZ / 1000)
`define UAD_DEFAULT_WAIT_MS 10
`define UAD_DCD_CYCLES 16'd200
`define UAD_TYPE1_USB 2
`define UAD_TYPE1_UART 3
`define UAD_TYPE1_CARKIT 4
`define UAD_TYPE1_DCP 6
`define UAD_TYPE1_CDP 5
`define UAD_TYPE1_AUDIO 0
`define UAD_TYPE2_BOOT_OFF_USB 0
`define UAD_TYPE2_BOOT_ON_USB 1
`define UAD_TYPE2_BOOT_OFF_UART 2
`define UAD_TYPE2_BOOT_ON_UART 3
`define UAD_TYPE2_TTY 4
`define UAD_TYPE2_CRADLE 5
`define UAD_CODE_FLOAT 5'h1F
`define UAD_CODE_AUDIO1 5'h1E
`define UAD_CODE_CARKIT1 5'h17
`define UAD_CODE_CARKIT2 5'h1B
`endif

// ==== hw/uad_classify.v ====
// Combinational classifier of the 5-bit ID code into result register images
`timescale 1ns/1ps
module uad_classify (
  input wire [4:0] code,
  input wire bus_power,
  input wire [1:0] port_kind,
  output reg [7:0] type_first,
  output reg [7:0] type_second,
  output reg [7:0] button_first,
  output reg [7:0] button_second,
  output reg [7:0] car_kit,
  output reg reserved_hit,
  output reg usb_charger
);
`include "uad_regs.vh"
  // =====================================
  // Code decode
  always @*
  begin
    type_first = 8'h00;
    type_second = 8'h00;
    button_first = 8'h00;
    button_second = 8'h00;
    car_kit = 8'h00;
    reserved_hit = 1'b0;
    usb_charger = 1'b0;
    if (code == 5'h01)
      button_first[0] = 1'b1;
    else if (code >= 5'h02 && code <= 5'h0D)
    begin
      // Remote buttons two to thirteen over two registers
      if (code <= 5'h08)
        button_first[code[2:0] - 3'h1] = 1'b1;
      else
        button_second[code[2:0] - 3'h1] = 1'b1;
    end
    else if (code >= 5'h0E && code <= 5'h12)
      reserved_hit = 1'b1;
    else
    begin
      case (code)
        5'h15: type_second[`UAD_TYPE2_TTY] = 1'b1;
        5'h16: type_first[`UAD_TYPE1_UART] = 1'b1;
        5'h18: type_second[`UAD_TYPE2_BOOT_OFF_USB] = 1'b1;
        5'h19: type_second[`UAD_TYPE2_BOOT_ON_USB] = 1'b1;
        5'h1A: type_second[`UAD_TYPE2_CRADLE] = 1'b1;
        5'h1C: type_second[`UAD_TYPE2_BOOT_OFF_UART] = 1'b1;
        5'h1D: type_second[`UAD_TYPE2_BOOT_ON_UART] = 1'b1;
        `UAD_CODE_AUDIO1: type_first[`UAD_TYPE1_AUDIO] = 1'b1;
        `UAD_CODE_CARKIT1, `UAD_CODE_CARKIT2:
        begin
          if (bus_power)
          begin
            type_first[`UAD_TYPE1_CARKIT] = 1'b1;
            car_kit = (code == `UAD_CODE_CARKIT1) ? 8'h01 : 8'h02;
          end
        end
        `UAD_CODE_FLOAT:
        begin
          if (bus_power)
          begin
            case (port_kind)
              2'd1: type_first[`UAD_TYPE1_DCP] = 1'b1;
              2'd2: type_first[`UAD_TYPE1_CDP] = 1'b1;
              default: type_first[`UAD_TYPE1_USB] = 1'b1;
            endcase
            usb_charger = (port_kind != 2'd0);
          end
        end
        default: type_first = 8'h00;
      endcase
    end
  end
endmodule // uad_classify

// ==== hw/uad_detect.v ====
// Accessory detector top: detection sequence, register file and host signalling
`timescale 1ns/1ps
module uad_detect (
  input wire ref_clk,
  input wire reset,
  input wire bus_power_pin,
  input wire [4:0] id_sense_pin,
  input wire usb_plus_line,
  input wire usb_minus_line,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_ff,
  output reg irq_line_n_ff,
  output reg charger_flag_pin_ff
);
`include "uad_regs.vh"
  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_WAIT = 5'b00010;
  localparam [4:0] ST_DCD = 5'b00100;
  localparam [4:0] ST_REPORT = 5'b01000;
  localparam [4:0] ST_ATTACHED = 5'b10000;
  localparam [31:0] DEFAULT_WAIT_CYC = `UAD_DEFAULT_WAIT_MS * `UAD_CYC_PER_MS;

  // =====================================
  // Pin synchronisers, three stages
  reg [6:0] sync1_ff;
  reg [6:0] sync2_ff;
  reg [6:0] sync3_ff;
  reg [6:0] stable_ff;
  wire [6:0] pin_raw = {usb_plus_line, bus_power_pin, id_sense_pin};
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1)
    begin : g_sync
      always @(posedge ref_clk or posedge reset)
      begin
        if (reset)
        begin
          sync1_ff[gi] <= (gi < 5) ? 1'b1 : 1'b0;
          sync2_ff[gi] <= (gi < 5) ? 1'b1 : 1'b0;
          sync3_ff[gi] <= (gi < 5) ? 1'b1 : 1'b0;
          stable_ff[gi] <= (gi < 5) ? 1'b1 : 1'b0;
        end
        else
        begin
          sync1_ff[gi] <= pin_raw[gi];
          sync2_ff[gi] <= sync1_ff[gi];
          sync3_ff[gi] <= sync2_ff[gi];
          if (sync2_ff[gi] == sync3_ff[gi])
            stable_ff[gi] <= sync3_ff[gi];
        end
      end
    end
  endgenerate
  wire [4:0] id_code = stable_ff[4:0];
  wire bus_power = stable_ff[5];
  wire dp_in = stable_ff[6];

  // =====================================
  // Register file
  reg [7:0] control_ff;
  reg [7:0] mask_first_ff;
  reg [7:0] mask_second_ff;
  reg [7:0] timing_first_ff;
  reg [7:0] timing_second_ff;
  reg [7:0] irq_first_ff;
  reg [7:0] irq_second_ff;
  reg [7:0] id_result_ff;
  reg [7:0] type_first_ff;
  reg [7:0] type_second_ff;
  reg [7:0] button_first_ff;
  reg [7:0] button_second_ff;
  reg [7:0] car_kit_ff;
  wire wr_ctrl = reg_wr && (reg_addr == `UAD_ADDR_CONTROL);
  wire block_bit = control_ff[`UAD_CTRL_BLOCK_BIT];

  // =====================================
  // Detection state machine
  reg [4:0] state_ff;
  reg [4:0] nxt_state;
  reg [31:0] count_ff;
  reg [31:0] nxt_count;
  reg [4:0] code_ff;
  reg [4:0] nxt_code;
  reg power_ff;
  reg nxt_power;
  reg [1:0] port_kind_ff;
  reg [1:0] nxt_port_kind;
  reg attached_ff;
  reg nxt_attached;
  reg report_pulse;
  reg detach_pulse;
  wire [31:0] wait_cyc;
  wire [7:0] cls_type_first;
  wire [7:0] cls_type_second;
  wire [7:0] cls_button_first;
  wire [7:0] cls_button_second;
  wire [7:0] cls_car_kit;
  wire cls_reserved;
  wire cls_charger;
  reg minus_sync1_ff;
  reg minus_sync2_ff;
  reg minus_sync3_ff;
  reg minus_hi_ff;
  wire charger_probe;

  // Switch wait from the high nibble of timing two; zero selects the default
  assign wait_cyc = (timing_second_ff[7:4] == 4'h0) ? DEFAULT_WAIT_CYC :
    ({28'd0, timing_second_ff[7:4]} * `UAD_WAIT_UNIT_MS * `UAD_CYC_PER_MS);

  uad_classify u_classify (
    .code(code_ff),
    .bus_power(power_ff),
    .port_kind(port_kind_ff),
    .type_first(cls_type_first),
    .type_second(cls_type_second),
    .button_first(cls_button_first),
    .button_second(cls_button_second),
    .car_kit(cls_car_kit),
    .reserved_hit(cls_reserved),
    .usb_charger(cls_charger)
  );

  wire input_changed = (id_code != code_ff) || (bus_power != power_ff);

  always @*
  begin
    nxt_state = state_ff;
    nxt_count = count_ff;
    nxt_code = code_ff;
    nxt_power = power_ff;
    nxt_port_kind = port_kind_ff;
    nxt_attached = attached_ff;
    report_pulse = 1'b0;
    detach_pulse = 1'b0;
    case (state_ff)
      ST_IDLE, ST_ATTACHED:
      begin
        if (input_changed)
        begin
          nxt_code = id_code;
          nxt_power = bus_power;
          nxt_count = 32'd0;
          nxt_state = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        if (input_changed)
        begin
          nxt_code = id_code;
          nxt_power = bus_power;
          nxt_count = 32'd0;
        end
        else if (count_ff + 32'd1 >= wait_cyc)
        begin
          nxt_count = 32'd0;
          if (code_ff == `UAD_CODE_FLOAT && power_ff)
            nxt_state = ST_DCD;
          else if (code_ff == `UAD_CODE_FLOAT)
          begin
            nxt_port_kind = 2'd0;
            if (attached_ff)
              detach_pulse = 1'b1;
            nxt_attached = 1'b0;
            nxt_state = ST_IDLE;
          end
          else
            nxt_state = ST_REPORT;
        end
        else
          nxt_count = count_ff + 32'd1;
      end
      ST_DCD:
      begin
        // Data contact: plus line must hold level for the debounce count
        if (input_changed)
          nxt_state = ST_WAIT;
        else if (sync2_ff[6] != sync3_ff[6])
          nxt_count = 32'd0;
        else if (count_ff >= {16'd0, `UAD_DCD_CYCLES})
        begin
          // Primary/secondary outcome read from the two data lines
          if (!dp_in)
            nxt_port_kind = 2'd0;
          else if (stable_ff[6] && minus_hi_ff)
            nxt_port_kind = 2'd1;
          else
            nxt_port_kind = 2'd2;
          nxt_state = ST_REPORT;
        end
        else
          nxt_count = count_ff + 32'd1;
      end
      ST_REPORT:
      begin
        report_pulse = 1'b1;
        nxt_attached = 1'b1;
        nxt_state = ST_ATTACHED;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      minus_hi_ff <= 1'b0;
    else
      minus_hi_ff <= sync3_ff[6] & sync2_ff[6] & (sync3_ff[6] == sync2_ff[6]) & charger_probe;
  end
  assign charger_probe = (minus_sync3_ff == minus_sync2_ff) & minus_sync3_ff;
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      minus_sync1_ff <= 1'b0;
      minus_sync2_ff <= 1'b0;
      minus_sync3_ff <= 1'b0;
    end
    else
    begin
      minus_sync1_ff <= usb_minus_line;
      minus_sync2_ff <= minus_sync1_ff;
      minus_sync3_ff <= minus_sync2_ff;
    end
  end

  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      state_ff <= ST_IDLE;
      count_ff <= 32'd0;
      code_ff <= `UAD_CODE_FLOAT;
      power_ff <= 1'b0;
      port_kind_ff <= 2'd0;
      attached_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      count_ff <= nxt_count;
      code_ff <= nxt_code;
      power_ff <= nxt_power;
      port_kind_ff <= nxt_port_kind;
      attached_ff <= nxt_attached;
    end
  end

  // =====================================
  // Register writes, results and event flags
  wire rd_irq_first = reg_rd && (reg_addr == `UAD_ADDR_IRQ_FIRST);
  wire rd_irq_second = reg_rd && (reg_addr == `UAD_ADDR_IRQ_SECOND);
  wire [7:0] ev_first = {6'd0, detach_pulse, report_pulse & ~cls_reserved};
  wire [7:0] ev_second = {5'd0, report_pulse, 1'b0, report_pulse & cls_reserved};
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      control_ff <= `UAD_CTRL_RESET;
      mask_first_ff <= `UAD_MASK_RESET;
      mask_second_ff <= `UAD_MASK_RESET;
      timing_first_ff <= `UAD_TIMING_RESET;
      timing_second_ff <= `UAD_TIMING_RESET;
      irq_first_ff <= 8'h00;
      irq_second_ff <= 8'h00;
      id_result_ff <= {3'd0, `UAD_CODE_FLOAT};
      type_first_ff <= 8'h00;
      type_second_ff <= 8'h00;
      button_first_ff <= 8'h00;
      button_second_ff <= 8'h00;
      car_kit_ff <= 8'h00;
    end
    else
    begin
      if (wr_ctrl)
        control_ff <= reg_wdata;
      if (reg_wr && reg_addr == `UAD_ADDR_MASK_FIRST)
        mask_first_ff <= reg_wdata;
      if (reg_wr && reg_addr == `UAD_ADDR_MASK_SECOND)
        mask_second_ff <= reg_wdata;
      if (reg_wr && reg_addr == `UAD_ADDR_TIMING_FIRST)
        timing_first_ff <= reg_wdata;
      if (reg_wr && reg_addr == `UAD_ADDR_TIMING_SECOND)
        timing_second_ff <= reg_wdata;
      // Set wins over the read clear
      irq_first_ff <= (rd_irq_first ? 8'h00 : irq_first_ff) | ev_first;
      irq_second_ff <= (rd_irq_second ? 8'h00 : irq_second_ff) | ev_second;
      if (report_pulse)
      begin
        id_result_ff <= {3'd0, code_ff};
        type_first_ff <= cls_type_first;
        type_second_ff <= cls_type_second;
        button_first_ff <= cls_button_first;
        button_second_ff <= cls_button_second;
        car_kit_ff <= cls_car_kit;
      end
      else if (detach_pulse)
      begin
        id_result_ff <= {3'd0, `UAD_CODE_FLOAT};
        type_first_ff <= 8'h00;
        type_second_ff <= 8'h00;
        button_first_ff <= 8'h00;
        button_second_ff <= 8'h00;
        car_kit_ff <= 8'h00;
      end
    end
  end

  // =====================================
  // Host signalling and read data
  reg powerup_ff;
  wire pend = |(irq_first_ff & ~mask_first_ff) | |(irq_second_ff & ~mask_second_ff);
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      powerup_ff <= 1'b1;
      irq_line_n_ff <= 1'b0;
      charger_flag_pin_ff <= 1'b1;
      reg_rdata_ff <= 8'h00;
    end
    else
    begin
      if (!block_bit)
        powerup_ff <= 1'b0;
      // Low after reset until first unblock, then high while blocked, else low on pending events
      if (powerup_ff && block_bit)
        irq_line_n_ff <= 1'b0;
      else if (block_bit)
        irq_line_n_ff <= 1'b1;
      else
        irq_line_n_ff <= ~pend;
      if (report_pulse)
        charger_flag_pin_ff <= ~cls_charger;
      else if (detach_pulse)
        charger_flag_pin_ff <= 1'b1;
      case (reg_addr)
        `UAD_ADDR_CONTROL: reg_rdata_ff <= control_ff;
        `UAD_ADDR_IRQ_FIRST: reg_rdata_ff <= irq_first_ff;
        `UAD_ADDR_IRQ_SECOND: reg_rdata_ff <= irq_second_ff;
        `UAD_ADDR_MASK_FIRST: reg_rdata_ff <= mask_first_ff;
        `UAD_ADDR_MASK_SECOND: reg_rdata_ff <= mask_second_ff;
        `UAD_ADDR_ID_CODE: reg_rdata_ff <= id_result_ff;
        `UAD_ADDR_TIMING_FIRST: reg_rdata_ff <= timing_first_ff;
        `UAD_ADDR_TIMING_SECOND: reg_rdata_ff <= timing_second_ff;
        `UAD_ADDR_TYPE_FIRST: reg_rdata_ff <= type_first_ff;
        `UAD_ADDR_TYPE_SECOND: reg_rdata_ff <= type_second_ff;
        `UAD_ADDR_BUTTON_FIRST: reg_rdata_ff <= button_first_ff;
        `UAD_ADDR_BUTTON_SECOND: reg_rdata_ff <= button_second_ff;
        `UAD_ADDR_CAR_KIT: reg_rdata_ff <= car_kit_ff;
        default: reg_rdata_ff <= 8'h00;
      endcase
    end
  end
endmodule // uad_detect

// ==== bench/uad_detect_assertions.sv ====
// Port checker of the accessory detector
`timescale 1ns/1ps
`include "uad_regs.vh"
module uad_detect_assertions (
  input wire ref_clk,
  input wire reset,
  input wire bus_power_pin,
  input wire [4:0] id_sense_pin,
  input wire usb_plus_line,
  input wire usb_minus_line,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata_ff,
  input wire irq_line_n_ff,
  input wire charger_flag_pin_ff
);
  reg blk_ff;
  reg opened_ff;
  reg [7:0] mask2_ff;
  reg [19:0] quiet_ff;
  reg [4:0] id_prev_ff;
  reg pwr_prev_ff;
  reg [3:0] tim_ff;
  localparam integer DEF_WAIT = `UAD_DEFAULT_WAIT_MS * `UAD_CYC_PER_MS;
  localparam integer UNIT_WAIT = `UAD_WAIT_UNIT_MS * `UAD_CYC_PER_MS;
  reg [2:0] wr_hist_ff;
  // ==========================================
  // Shadow of control, mask and input quiet time
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      blk_ff <= 1'h1;
      opened_ff <= 1'h0;
      mask2_ff <= `UAD_MASK_RESET;
      quiet_ff <= 20'h00000;
      wr_hist_ff <= 3'h0;
      id_prev_ff <= `UAD_CODE_FLOAT;
      pwr_prev_ff <= 1'h0;
      tim_ff <= 4'h0;
    end
    else
    begin
      wr_hist_ff <= {wr_hist_ff[1:0], reg_wr};
      if (reg_wr && reg_addr == `UAD_ADDR_CONTROL)
      begin
        blk_ff <= reg_wdata[0];
        opened_ff <= opened_ff | ~reg_wdata[0];
      end
      if (reg_wr && reg_addr == `UAD_ADDR_MASK_SECOND)
        mask2_ff <= reg_wdata;
      id_prev_ff <= id_sense_pin;
      pwr_prev_ff <= bus_power_pin;
      if (reg_wr && reg_addr == `UAD_ADDR_TIMING_SECOND)
        tim_ff <= reg_wdata[7:4];
      if (id_sense_pin != id_prev_ff || bus_power_pin != pwr_prev_ff)
        quiet_ff <= 20'h00000;
      else if (quiet_ff != 20'hFFFFF)
        quiet_ff <= quiet_ff + 20'h00001;
    end
  end
  // ==========================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_reset_masked: assert property ($fell(reset) |-> !irq_line_n_ff)
    else $error("interrupt not low after reset");
  a_block_quiet: assert property (blk_ff && opened_ff |=> irq_line_n_ff)
    else $error("interrupt low while blocked");
  a_read_release: assert property ((reg_rd && reg_addr == `UAD_ADDR_IRQ_FIRST &&
    mask2_ff == 8'hFF && opened_ff) |=> ##1 irq_line_n_ff)
    else $error("interrupt not released by read");
  a_irq_hold: assert property ((!irq_line_n_ff && !reg_rd && !reg_wr && !$past(reg_rd)
    && !$past(reg_wr)) |=> !irq_line_n_ff)
    else $error("interrupt released without read");
  a_ctrl_readback: assert property ((reg_addr == `UAD_ADDR_CONTROL && !reg_wr)
    |=> reg_rdata_ff[0] == $past(blk_ff))
    else $error("block bit read back wrong");
  a_wait_floor: assert property (($fell(irq_line_n_ff) && wr_hist_ff == 3'h0)
    |-> quiet_ff >= ((tim_ff == 4'h0) ? DEF_WAIT : tim_ff * UNIT_WAIT))
    else $error("report before switch wait");
  a_charger_cause: assert property ($fell(charger_flag_pin_ff)
    |-> bus_power_pin && id_sense_pin == `UAD_CODE_FLOAT)
    else $error("charger flag without charger");
  a_charger_end: assert property ($rose(charger_flag_pin_ff) |-> !bus_power_pin)
    else $error("charger flag left with power");
endmodule // uad_detect_assertions
bind uad_detect uad_detect_assertions i_chk (.ref_clk(ref_clk), .reset(reset),
  .bus_power_pin(bus_power_pin), .id_sense_pin(id_sense_pin),
  .usb_plus_line(usb_plus_line), .usb_minus_line(usb_minus_line), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata_ff(reg_rdata_ff), .irq_line_n_ff(irq_line_n_ff),
  .charger_flag_pin_ff(charger_flag_pin_ff));

// ==== bench/uad_accessory_model.sv ====
// Model of the accessory on the connector
`timescale 1ns/1ps
module uad_accessory_model (
  input wire ref_clk,
  output reg bus_power,
  output reg [4:0] id_code,
  output reg plus_line,
  output reg minus_line
);
  reg [1:0] port_kind;
  initial
  begin
    bus_power = 1'h0;
    id_code = 5'h1F;
    port_kind = 2'h3;
    plus_line = 1'h0;
    minus_line = 1'h1;
  end
  // ==========================================
  // Data lines held by port kind, wandering without a port
  always @(negedge ref_clk)
  begin
    plus_line <= (port_kind == 2'h3) ? ~plus_line : (port_kind != 2'h0);
    minus_line <= (port_kind == 2'h3) ? plus_line : (port_kind == 2'h1);
  end
  // ==========================================
  // Plug event, power first then ID code
  task plug(input logic pwr, input logic [4:0] code, input logic [1:0] kind);
  begin
    @(negedge ref_clk);
    bus_power = pwr;
    port_kind = pwr ? kind : 2'h3;
    repeat (5) @(negedge ref_clk);
    id_code = code;
  end
  endtask
endmodule // uad_accessory_model

// ==== bench/uad_detect_tb_top.sv ====
// Testbench of the accessory detector
`timescale 1ns/1ps
`include "uad_regs.vh"
module uad_detect_tb_top;
  reg ref_clk = 1'h0;
  reg reset = 1'h1;
  reg reg_wr = 1'h0;
  reg reg_rd = 1'h0;
  reg [7:0] reg_addr = 8'h00;
  reg [7:0] reg_wdata = 8'h00;
  wire bus_power_pin;
  wire [4:0] id_sense_pin;
  wire usb_plus_line;
  wire usb_minus_line;
  wire [7:0] reg_rdata_ff;
  wire irq_line_n_ff;
  wire charger_flag_pin_ff;
  integer seed = 8;
  integer err_count = 0;
  integer compares = 0;
  integer cyc;
  reg [7:0] rv;
  reg [7:0] val;
  reg [4:0] code;
  always #25 ref_clk = ~ref_clk;
  uad_accessory_model i_acc (.ref_clk(ref_clk), .bus_power(bus_power_pin),
    .id_code(id_sense_pin), .plus_line(usb_plus_line), .minus_line(usb_minus_line));
  uad_detect i_dut (.ref_clk(ref_clk), .reset(reset), .bus_power_pin(bus_power_pin),
    .id_sense_pin(id_sense_pin), .usb_plus_line(usb_plus_line),
    .usb_minus_line(usb_minus_line), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
    .irq_line_n_ff(irq_line_n_ff), .charger_flag_pin_ff(charger_flag_pin_ff));
  // ==========================================
  // Helpers
  function [15:0] btn_exp(input [4:0] c);
    btn_exp = 16'h0001 << (c - 5'h01);
  endfunction
  task check(input [15:0] got, input [15:0] exp);
  begin
    compares = compares + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task close_out;
  begin
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(negedge ref_clk);
    reg_wr = 1'h1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr = 1'h0;
  end
  endtask
  task rd(input [7:0] a, output [7:0] d);
  begin
    @(negedge ref_clk);
    reg_rd = 1'h1;
    reg_addr = a;
    @(negedge ref_clk);
    reg_rd = 1'h0;
    d = reg_rdata_ff;
  end
  endtask
  task wrc(input [7:0] a, input [7:0] d);
  begin
    wr(a, d);
    rd(a, rv);
    check(rv, d);
  end
  endtask
  task run(input pwr, input [4:0] c, input [1:0] k, input [7:0] flags);
  begin
    i_acc.plug(pwr, c, k);
    cyc = 0;
    await_irq(flags, `UAD_WAIT_UNIT_MS * `UAD_CYC_PER_MS - 10,
      `UAD_WAIT_UNIT_MS * `UAD_CYC_PER_MS + 1000);
  end
  endtask
  task await_irq(input [7:0] flags, input integer lo, input integer hi);
  begin
    while (irq_line_n_ff !== 1'h0 && cyc < hi)
    begin
      @(negedge ref_clk);
      cyc = cyc + 1;
    end
    check(cyc < hi, 1'h1);
    check(cyc >= lo, 1'h1);
    rd(`UAD_ADDR_IRQ_FIRST, rv);
    check(rv, flags);
    @(negedge ref_clk);
    check(irq_line_n_ff, 1'h1);
  end
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    reset = 1'h0;
    check(irq_line_n_ff, 1'h0);
    rd(`UAD_ADDR_CONTROL, rv);
    check(rv, `UAD_CTRL_RESET);
    rd(`UAD_ADDR_TIMING_FIRST, rv);
    check(rv, `UAD_TIMING_RESET);
    rd(`UAD_ADDR_TIMING_SECOND, rv);
    check(rv, `UAD_TIMING_RESET);
    val = $random(seed);
    wrc(`UAD_ADDR_MASK_FIRST, val & 8'hFC);
    wrc(`UAD_ADDR_MASK_SECOND, 8'hFF);
    wrc(`UAD_ADDR_TIMING_FIRST, val);
    wrc(`UAD_ADDR_TIMING_SECOND, val & 8'h0F);
    rd(`UAD_ADDR_ID_CODE, val);
    check(val, {3'h0, `UAD_CODE_FLOAT});
    wr(`UAD_ADDR_ID_CODE, ~val);
    rd(`UAD_ADDR_ID_CODE, rv);
    check(rv, val);
    rd(8'h1A, rv);
    check(rv, 8'h00);
    wr(`UAD_ADDR_CONTROL, 8'h1E);
    repeat (2) @(negedge ref_clk);
    check(irq_line_n_ff, 1'h1);
    wr(`UAD_ADDR_CONTROL, 8'h1F);
    repeat (2) @(negedge ref_clk);
    check(irq_line_n_ff, 1'h1);
    wrc(`UAD_ADDR_CONTROL, 8'h1E);
    $display("test registers done");
    code = 5'h02 + ($unsigned($random(seed)) % 12);
    i_acc.plug(1'h0, code, 2'h0);
    repeat (25000) @(negedge ref_clk);
    check(irq_line_n_ff, 1'h1);
    wrc(`UAD_ADDR_TIMING_SECOND, 8'h10);
    cyc = 0;
    await_irq(8'h01, 1, 100);
    rd(`UAD_ADDR_ID_CODE, rv);
    check(rv, {3'h0, code});
    rd(`UAD_ADDR_BUTTON_FIRST, rv);
    rd(`UAD_ADDR_BUTTON_SECOND, val);
    check({val, rv}, btn_exp(code));
    $display("test remote button done");
    run(1'h0, `UAD_CODE_AUDIO1, 2'h0, 8'h01);
    rd(`UAD_ADDR_TYPE_FIRST, rv);
    check(rv, 8'h01 << `UAD_TYPE1_AUDIO);
    $display("test audio type done");
    run(1'h1, `UAD_CODE_FLOAT, 2'h1, 8'h01);
    check(charger_flag_pin_ff, 1'h0);
    rd(`UAD_ADDR_TYPE_FIRST, rv);
    check(rv, 8'h01 << `UAD_TYPE1_DCP);
    $display("test dedicated charger done");
    run(1'h0, `UAD_CODE_FLOAT, 2'h0, 8'h02);
    check(charger_flag_pin_ff, 1'h1);
    rd(`UAD_ADDR_ID_CODE, rv);
    check(rv, 8'h1F);
    $display("test detach done");
    close_out;
  end
endmodule // uad_detect_tb_top
